// File: hdl/lcc_pkg.sv
// Shared constants and types for the logic cell cluster
package lcc_pkg;

	// Cluster geometry
	localparam int CELLS     = 8;
	localparam int LINES     = 4;
	localparam int CLK_LINES = 2;
	localparam int LUT_W     = 16;
	localparam int MODE_W    = 4;
	localparam int FF_W      = 4;
	localparam int SRC_W     = 2;
	localparam int IDX_W     = 6;
	localparam int FLAG_W    = 10;
	localparam int SYNC_W    = 11;

	// Control line roles
	localparam int LINE_CLR = 2;
	localparam int LINE_PRE = 3;

	// Control line source codes
	localparam logic [1:0] SRC_PIN      = 2'h0;
	localparam logic [1:0] SRC_GLOBAL   = 2'h1;
	localparam logic [1:0] SRC_IO       = 2'h2;
	localparam logic [1:0] SRC_INTERNAL = 2'h3;

	// Chain segment starts: first pair of a row, first pair past the memory block
	localparam logic [5:0] ROW_PAIR_END = 6'h02;
	localparam logic [5:0] ROW_MID_IDX  = 6'h12;
	localparam logic       CARRY_NEUTRAL = 1'b0;
	localparam logic       CASC_NEUTRAL  = 1'b1;

	// Reset values
	localparam logic              Q_RST    = 1'b0;
	localparam logic [SYNC_W-1:0] SYNC_RST = 11'h400;

	// Width of the whole static configuration word
	localparam int CFG_W = CELLS * (LUT_W + MODE_W + FF_W + FLAG_W) + LINES * (SRC_W + 1) + 1 + IDX_W;

	typedef enum logic [3:0] {
		LCC_NORMAL = 4'h1,
		LCC_ARITH  = 4'h2,
		LCC_UPDN   = 4'h4,
		LCC_CLRCNT = 4'h8
	} lcc_mode_t;

	typedef enum logic [3:0] {
		LCC_FF_D  = 4'h1,
		LCC_FF_T  = 4'h2,
		LCC_FF_JK = 4'h4,
		LCC_FF_SR = 4'h8
	} lcc_ff_t;

endpackage

// File: hdl/lcc_cell.sv
// One logic cell: table, programmable register, carry and cascade links
`timescale 1ns/100ps
module lcc_cell (
	input  wire logic               clk,         // Cluster clock
	input  wire logic               rst_n,       // Sync reset, active low
	input  wire lcc_pkg::lcc_mode_t mode,        // Operating mode
	input  wire lcc_pkg::lcc_ff_t   ff_type,     // Register behaviour
	input  wire logic [15:0]        mask,        // Table contents
	input  wire logic               local_sel,   // Local output: 1 register, 0 table
	input  wire logic               route_sel,   // Routing output: 1 register, 0 table
	input  wire logic               cen_d1,      // Input one drives clock enable
	input  wire logic               carry_d3,    // Carry replaces input three
	input  wire logic               reg_d4,      // Input four feeds register directly
	input  wire logic               casc_or,     // Cascade joins by OR
	input  wire logic               acc,         // Register is second adder operand
	input  wire logic               clr_en,      // Clear line acts on this cell
	input  wire logic               pre_en,      // Preset line acts on this cell
	input  wire logic [3:0]         d,           // Four data inputs
	input  wire logic               carry_in,    // From lower-order cell
	input  wire logic               cascade_in,  // From previous cell
	input  wire logic               tick,        // Selected clock line edge
	input  wire logic               clr_line_n,  // Clear line, active low
	input  wire logic               pre_line_n,  // Preset line, active low
	input  wire logic               chip_clr,    // Chip-wide reset, active high
	output logic                    carry_out,   // To higher-order cell
	output logic                    cascade_out, // To next cell
	output logic                    local_out,   // Toward local routing
	output logic                    route_out    // Toward row or column routing
);
	import lcc_pkg::*;

	logic q_ff;
	logic nxt_q;

	// Join a table value with the incoming cascade, OR through inversion
	function automatic logic casc_fn(input logic v, input logic cin, input logic use_or);
		casc_fn = use_or ? ~(~v & ~cin) : (v & cin);
	endfunction

	// Register behaviour; a is D, T, J or S, b is K or R
	function automatic logic ff_fn(input lcc_ff_t t, input logic q, input logic a, input logic b);
		unique case (t)
			LCC_FF_D:  ff_fn = a;
			LCC_FF_T:  ff_fn = q ^ a;
			LCC_FF_JK: ff_fn = (~q & a) | (q & ~b);
			LCC_FF_SR: ff_fn = a ? 1'b1 : (b ? 1'b0 : q);
			default:   ff_fn = q;
		endcase
	endfunction

	// Input steering per mode
	wire [3:0] n_idx  = {d[3], carry_d3 ? carry_in : d[2], d[1], d[0]};
	wire       opb    = acc ? q_ff : d[1];
	wire [2:0] a_idx  = {carry_in, opb, d[0]};
	wire       dir    = (mode == LCC_UPDN) ? d[2] : 1'b0;
	wire [2:0] c_idx  = {carry_in, dir, q_ff};

	// Table halves; the upper eight entries hold the carry function
	wire       lut4   = mask[n_idx];
	wire       casc   = casc_fn(lut4, cascade_in, casc_or);
	wire       sum    = mask[{1'b0, a_idx}];
	wire       a_cy   = mask[{1'b1, a_idx}];
	wire       cnt    = d[1] ? mask[{1'b0, c_idx}] : q_ff;
	wire       cnt_cy = mask[{1'b1, c_idx}];
	wire       ld_mux = d[3] ? cascade_in : cnt;
	wire       clr_ld = ld_mux & d[2];
	wire       is_cnt = (mode == LCC_UPDN) || (mode == LCC_CLRCNT);

	// Mode result and register input; packing lets input four bypass the table
	wire comb   = (mode == LCC_ARITH) ? sum :
	              (mode == LCC_UPDN) ? ld_mux :
	              (mode == LCC_CLRCNT) ? clr_ld : casc;
	wire reg_in = (mode == LCC_NORMAL && reg_d4) ? d[3] : comb;

	// Chain outputs; normal mode passes the carry onward
	assign carry_out   = (mode == LCC_ARITH) ? a_cy : (is_cnt ? cnt_cy : carry_in);
	assign cascade_out = (mode == LCC_ARITH) ? casc_fn(sum, cascade_in, casc_or) :
	                     (is_cnt ? CASC_NEUTRAL : casc);

	// Enable gating and clear priority; chip reset beats every control
	wire cen   = cen_d1 ? d[0] : 1'b1;
	wire take  = tick & cen;
	wire clr_n = clr_en ? clr_line_n : 1'b1;
	wire pre_n = pre_en ? pre_line_n : 1'b1;
	assign nxt_q = chip_clr ? 1'b0 : (!clr_n ? 1'b0 : (!pre_n ? 1'b1 :
	               (take ? ff_fn(ff_type, q_ff, reg_in, d[2]) : q_ff)));

	// Cell register; controls are sampled levels, not a second domain
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q_ff <= Q_RST;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// Two outputs chosen apart; table choice bypasses the register
	assign local_out = local_sel ? q_ff : comb;
	assign route_out = route_sel ? q_ff : comb;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	wire quiet = !chip_clr && clr_n && pre_n;

	chk_cen_hold: assert property (tick && !cen && quiet |=> $stable(q_ff))
		else $error("register moved with enable low");
	chk_idle_hold: assert property (!tick && quiet |=> $stable(q_ff))
		else $error("register moved without clock edge");
	chk_chip_over: assert property (chip_clr |=> !q_ff)
		else $error("chip reset did not clear register");
	chk_clear_wins: assert property (!chip_clr && !clr_n |=> !q_ff)
		else $error("clear did not clear register");
	chk_preset_sets: assert property (!chip_clr && clr_n && !pre_n |=> q_ff)
		else $error("preset did not set register");
	chk_d_capture: assert property (take && quiet && ff_type == LCC_FF_D |=> q_ff == $past(reg_in))
		else $error("D register missed its input");
	chk_t_toggle: assert property (take && quiet && ff_type == LCC_FF_T && reg_in |=> q_ff != $past(q_ff))
		else $error("T register did not toggle");
	chk_clr_count: assert property (mode == LCC_CLRCNT && !d[2] |-> !local_sel |-> !local_out)
		else $error("synchronous clear did not force zero");
endmodule

// File: hdl/lcc_cluster.sv
// Cluster of eight logic cells with shared control lines and chain links
`timescale 1ns/100ps
module lcc_cluster (
	input  wire logic                clk,             // Cluster clock
	input  wire logic                rst_n,           // Sync reset, active low
	input  wire logic                cfg_load,        // Capture configuration, one pulse
	input  wire logic [5:0]          cluster_idx,     // Position of cluster in its row
	input  wire logic [127:0]        cfg_mask,        // Table contents, 16 bits per cell
	input  wire logic [31:0]         cfg_mode,        // Mode codes, 4 bits per cell
	input  wire logic [31:0]         cfg_ff_type,     // Register types, 4 bits per cell
	input  wire logic [7:0]          cfg_local_sel,   // Local output from register
	input  wire logic [7:0]          cfg_route_sel,   // Routing output from register
	input  wire logic [7:0]          cfg_cen_d1,      // Input one is clock enable
	input  wire logic [7:0]          cfg_carry_d3,    // Carry replaces input three
	input  wire logic [7:0]          cfg_reg_d4,      // Input four feeds register
	input  wire logic [7:0]          cfg_casc_or,     // Cascade joins by OR
	input  wire logic [7:0]          cfg_acc,         // Accumulate in arithmetic mode
	input  wire logic [7:0]          cfg_clk_line,    // Clock line choice per cell
	input  wire logic [7:0]          cfg_clr_en,      // Clear line acts on cell
	input  wire logic [7:0]          cfg_pre_en,      // Preset line acts on cell
	input  wire logic [7:0]          cfg_ctl_src,     // Source code, 2 bits per line
	input  wire logic [3:0]          cfg_ctl_inv,     // Inversion per control line
	input  wire logic                cfg_chip_rst_en, // Chip reset acts on cluster
	input  wire logic [1:0]          clk_pin,         // Dedicated clock pins
	input  wire logic [3:0]          global_line,     // Global control lines
	input  wire logic [3:0]          io_sig,          // Pin cell signals
	input  wire logic [3:0]          internal_ctl,    // Internal logic controls
	input  wire logic                chip_rst_pin_n,  // Chip-wide reset pin, active low
	input  wire logic [31:0]         cell_data,       // Four data inputs per cell
	input  wire logic                carry_in,        // Carry from cluster two back
	input  wire logic                cascade_in,      // Cascade from cluster two back
	output logic [7:0]               local_out,       // Local outputs, registered
	output logic [7:0]               route_out,       // Routing outputs, registered
	output logic                     carry_out,       // Carry to cluster two ahead
	output logic                     cascade_out,     // Cascade to cluster two ahead
	output logic                     cfg_done         // Configuration in force
);
	import lcc_pkg::*;

	// Static configuration store
	logic [CFG_W-1:0]         cfg_ff;
	logic [CFG_W-1:0]         nxt_cfg;
	logic                     cfg_done_ff;
	logic                     nxt_cfg_done;

	// Unpacked configuration fields
	logic [IDX_W-1:0]         idx_c;
	logic                     rst_en_c;
	logic [LINES-1:0]         inv_c;
	logic [LINES*SRC_W-1:0]   src_c;
	logic [CELLS-1:0]         acc_c;
	logic [CELLS-1:0]         clkl_c;
	logic [CELLS-1:0]         clr_en_c;
	logic [CELLS-1:0]         pre_en_c;
	logic [CELLS-1:0]         cen_c;
	logic [CELLS-1:0]         cd3_c;
	logic [CELLS-1:0]         rd4_c;
	logic [CELLS-1:0]         cor_c;
	logic [CELLS-1:0]         lsel_c;
	logic [CELLS-1:0]         rsel_c;
	logic [CELLS*FF_W-1:0]    fft_c;
	logic [CELLS*MODE_W-1:0]  mode_c;
	logic [CELLS*LUT_W-1:0]   mask_c;

	// Synchronisers and control lines
	logic [SYNC_W-1:0]        sync1_ff;
	logic [SYNC_W-1:0]        sync2_ff;
	logic [CLK_LINES-1:0]     line_d_ff;
	logic [LINES-1:0]         line_val;
	logic [CLK_LINES-1:0]     tick;

	// Chains and cell outputs
	logic [CELLS:0]           carry_chain;
	logic [CELLS:0]           casc_chain;
	logic [CELLS-1:0]         cell_local;
	logic [CELLS-1:0]         cell_route;

	// Output registers
	logic [CELLS-1:0]         local_out_ff;
	logic [CELLS-1:0]         nxt_local_out;
	logic [CELLS-1:0]         route_out_ff;
	logic [CELLS-1:0]         nxt_route_out;
	logic                     carry_out_ff;
	logic                     nxt_carry_out;
	logic                     cascade_out_ff;
	logic                     nxt_cascade_out;

	// Pick one source for a control line
	function automatic logic ctl_pick(input logic [1:0] src, input logic pin, input logic glb,
	                                  input logic io, input logic intl);
		unique case (src)
			SRC_PIN:      ctl_pick = pin;
			SRC_GLOBAL:   ctl_pick = glb;
			SRC_IO:       ctl_pick = io;
			SRC_INTERNAL: ctl_pick = intl;
		endcase
	endfunction

	// Configuration is taken once; later loads are ignored until reset
	wire [CFG_W-1:0] cfg_in = {cluster_idx, cfg_chip_rst_en, cfg_ctl_inv, cfg_ctl_src,
	                           cfg_acc, cfg_clk_line, cfg_clr_en, cfg_pre_en,
	                           cfg_cen_d1, cfg_carry_d3, cfg_reg_d4, cfg_casc_or,
	                           cfg_local_sel, cfg_route_sel, cfg_ff_type, cfg_mode, cfg_mask};
	wire             cfg_take = cfg_load & ~cfg_done_ff;
	assign nxt_cfg      = cfg_take ? cfg_in : cfg_ff;
	assign nxt_cfg_done = cfg_done_ff | cfg_load;

	// Configuration store
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_ff      <= '0;
			cfg_done_ff <= 1'b0;
		end else begin
			cfg_ff      <= nxt_cfg;
			cfg_done_ff <= nxt_cfg_done;
		end
	end

	// Field split of the stored word
	assign {idx_c, rst_en_c, inv_c, src_c, acc_c, clkl_c, clr_en_c, pre_en_c,
	        cen_c, cd3_c, rd4_c, cor_c, lsel_c, rsel_c, fft_c, mode_c, mask_c} = cfg_ff;

	// Pins arrive unrelated to clk; two stages before anything reads them
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_ff <= SYNC_RST;
			sync2_ff <= SYNC_RST;
		end else begin
			sync1_ff <= {chip_rst_pin_n, io_sig, global_line, clk_pin};
			sync2_ff <= sync1_ff;
		end
	end

	// Synchronised pin groups
	wire [1:0] pin_s    = sync2_ff[1:0];
	wire [3:0] glb_s    = sync2_ff[5:2];
	wire [3:0] io_s     = sync2_ff[9:6];
	wire       crst_n_s = sync2_ff[10];

	// Clear and preset lines have no clock pin; that code falls to global
	wire [3:0] pin_ext  = {glb_s[3:2], pin_s};

	// Source choice and inversion for each shared line
	for (genvar j = 0; j < LINES; j++) begin : g_line
		assign line_val[j] = ctl_pick(src_c[SRC_W*j +: SRC_W], pin_ext[j], glb_s[j],
		                              io_s[j], internal_ctl[j]) ^ inv_c[j];
	end

	// Clock line history for edge detection
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_d_ff <= '0;
		end else begin
			line_d_ff <= line_val[CLK_LINES-1:0];
		end
	end

	// Rising edges of the two clock lines; cells stay still until configured
	assign tick = line_val[CLK_LINES-1:0] & ~line_d_ff & {CLK_LINES{cfg_done_ff}};

	// Chip reset overrides every clear, preset and load when enabled
	wire chip_clr = rst_en_c & ~crst_n_s;

	// Segment starts: first pair in a row, and the first pair past the memory block
	wire seg_start = (idx_c < ROW_PAIR_END) || (idx_c == ROW_MID_IDX) ||
	                 (idx_c == ROW_MID_IDX + 6'h01);

	// Neutral values keep a fresh segment from inheriting a stale chain
	assign carry_chain[0] = seg_start ? CARRY_NEUTRAL : carry_in;
	assign casc_chain[0]  = seg_start ? CASC_NEUTRAL : cascade_in;

	// Eight cells, chained low to high
	for (genvar i = 0; i < CELLS; i++) begin : g_cell
		wire cell_tick = clkl_c[i] ? tick[1] : tick[0];
		lcc_cell u_cell (
			.clk         (clk),
			.rst_n       (rst_n),
			.mode        (lcc_mode_t'(mode_c[MODE_W*i +: MODE_W])),
			.ff_type     (lcc_ff_t'(fft_c[FF_W*i +: FF_W])),
			.mask        (mask_c[LUT_W*i +: LUT_W]),
			.local_sel   (lsel_c[i]),
			.route_sel   (rsel_c[i]),
			.cen_d1      (cen_c[i]),
			.carry_d3    (cd3_c[i]),
			.reg_d4      (rd4_c[i]),
			.casc_or     (cor_c[i]),
			.acc         (acc_c[i]),
			.clr_en      (clr_en_c[i]),
			.pre_en      (pre_en_c[i]),
			.d           (cell_data[4*i +: 4]),
			.carry_in    (carry_chain[i]),
			.cascade_in  (casc_chain[i]),
			.tick        (cell_tick),
			.clr_line_n  (line_val[LINE_CLR]),
			.pre_line_n  (line_val[LINE_PRE]),
			.chip_clr    (chip_clr),
			.carry_out   (carry_chain[i+1]),
			.cascade_out (casc_chain[i+1]),
			.local_out   (cell_local[i]),
			.route_out   (cell_route[i])
		);
	end

	// Last cell hands both chains on to the cluster two places ahead
	assign nxt_local_out   = cell_local;
	assign nxt_route_out   = cell_route;
	assign nxt_carry_out   = carry_chain[CELLS];
	assign nxt_cascade_out = casc_chain[CELLS];

	// Output stage; costs one cycle but keeps every port on a flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			local_out_ff   <= '0;
			route_out_ff   <= '0;
			carry_out_ff   <= CARRY_NEUTRAL;
			cascade_out_ff <= CASC_NEUTRAL;
		end else begin
			local_out_ff   <= nxt_local_out;
			route_out_ff   <= nxt_route_out;
			carry_out_ff   <= nxt_carry_out;
			cascade_out_ff <= nxt_cascade_out;
		end
	end

	// Port drive
	assign local_out   = local_out_ff;
	assign route_out   = route_out_ff;
	assign carry_out   = carry_out_ff;
	assign cascade_out = cascade_out_ff;
	assign cfg_done    = cfg_done_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_cfg_static: assert property (cfg_done_ff |=> $stable(cfg_ff) && cfg_done_ff)
		else $error("configuration changed after load");
	chk_cfg_taken: assert property (cfg_load && !cfg_done_ff |=> cfg_ff == $past(cfg_in) && cfg_done)
		else $error("configuration load not captured");
	chk_tick_edge: assert property ($rose(line_val[0]) && cfg_done_ff |-> tick[0])
		else $error("clock line edge not seen");
	chk_tick_single: assert property (tick[1] |=> !tick[1])
		else $error("clock tick longer than a cycle");
	chk_seg_restart: assert property (idx_c == ROW_MID_IDX |-> !carry_chain[0] && casc_chain[0])
		else $error("chain not restarted past memory block");
	chk_chain_pass: assert property (!seg_start |-> carry_chain[0] == carry_in)
		else $error("carry from previous cluster lost");
	chk_out_pipe: assert property (1'b1 |=> local_out == $past(cell_local) && carry_out == $past(carry_chain[CELLS]))
		else $error("output stage out of step");

	cov_cfg_load: cover property (cfg_load ##1 cfg_done);
	cov_arith: cover property (cfg_done_ff && mode_c[3:0] == LCC_ARITH && tick[0]);
	cov_chip_clr: cover property (cfg_done_ff && chip_clr);
	cov_carry_out: cover property (cfg_done_ff && !seg_start && carry_out);
endmodule

// File: test/lcc_far_model.sv
// Far-side model: neighbour clusters that feed the chain inputs
`timescale 1ns/100ps
module lcc_far_model (
	input  wire logic clk,        // Cluster clock
	input  wire logic rst_n,      // Sync reset, active low
	output logic      carry_in,   // Chain carry toward the cluster
	output logic      cascade_in  // Chain cascade toward the cluster
);
	// A segment start must ignore its neighbours, so they show values that change every cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			carry_in   <= 1'b1;
			cascade_in <= 1'b0;
		end else begin
			carry_in   <= ~carry_in;
			cascade_in <= ~cascade_in;
		end
	end
endmodule

// File: test/tb.sv
// Self-checking bench for the logic cell cluster
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
	logic         clk, rst_n, cfg_load, cfg_chip_rst_en, chip_rst_pin_n;
	logic [5:0]   cluster_idx;
	logic [127:0] cfg_mask;
	logic [31:0]  cfg_mode, cfg_ff_type, cell_data;
	logic [7:0]   cfg_local_sel, cfg_route_sel, cfg_cen_d1, cfg_carry_d3, cfg_reg_d4, cfg_casc_or;
	logic [7:0]   cfg_acc, cfg_clk_line, cfg_clr_en, cfg_pre_en, cfg_ctl_src, local_out, route_out;
	logic [3:0]   cfg_ctl_inv, global_line, io_sig, internal_ctl;
	logic [1:0]   clk_pin;
	logic         carry_in, cascade_in, carry_out, cascade_out, cfg_done;
	int           miscompares, comparisons, cycles;

	lcc_cluster DUT (.clk(clk), .rst_n(rst_n), .cfg_load(cfg_load), .cluster_idx(cluster_idx),
		.cfg_mask(cfg_mask), .cfg_mode(cfg_mode), .cfg_ff_type(cfg_ff_type), .cfg_local_sel(cfg_local_sel),
		.cfg_route_sel(cfg_route_sel), .cfg_cen_d1(cfg_cen_d1), .cfg_carry_d3(cfg_carry_d3),
		.cfg_reg_d4(cfg_reg_d4), .cfg_casc_or(cfg_casc_or), .cfg_acc(cfg_acc), .cfg_clk_line(cfg_clk_line),
		.cfg_clr_en(cfg_clr_en), .cfg_pre_en(cfg_pre_en), .cfg_ctl_src(cfg_ctl_src), .cfg_ctl_inv(cfg_ctl_inv),
		.cfg_chip_rst_en(cfg_chip_rst_en), .clk_pin(clk_pin), .global_line(global_line), .io_sig(io_sig),
		.internal_ctl(internal_ctl), .chip_rst_pin_n(chip_rst_pin_n), .cell_data(cell_data),
		.carry_in(carry_in), .cascade_in(cascade_in), .local_out(local_out), .route_out(route_out),
		.carry_out(carry_out), .cascade_out(cascade_out), .cfg_done(cfg_done));
	lcc_far_model far (.clk(clk), .rst_n(rst_n), .carry_in(carry_in), .cascade_in(cascade_in));

	// Clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic end_sim();
		$display("Comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Hang guard, far above the ninety or so cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			end_sim();
		end
	end

	// Settled sample point after n rising edges
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	initial begin
		// Parity table everywhere; lines all internal; cell 1 gated by input one
		rst_n = 1'b0; cfg_load = 1'b0; cluster_idx = 6'h00; cfg_mask = {8{16'h6996}};
		cfg_mode = 32'h11111111; cfg_ff_type = 32'h11111111; cfg_local_sel = 8'h00; cfg_route_sel = 8'hFF;
		cfg_cen_d1 = 8'h02; cfg_carry_d3 = 8'h00; cfg_reg_d4 = 8'h00; cfg_casc_or = 8'h00; cfg_acc = 8'h00;
		cfg_clk_line = 8'h00; cfg_clr_en = 8'h01; cfg_pre_en = 8'h02; cfg_ctl_src = 8'hFF; cfg_ctl_inv = 4'h0;
		cfg_chip_rst_en = 1'b0; chip_rst_pin_n = 1'b1; clk_pin = 2'h0; global_line = 4'h0; io_sig = 4'h0;
		internal_ctl = 4'hC; cell_data = 32'h11111111;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK("route_out", 8'h00, route_out)
		`CHK("cascade_out", 1'b1, cascade_out)
		`CHK("cfg_done", 1'b0, cfg_done)
		@(posedge clk);
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		#1;
		`CHK("cfg_done", 1'b1, cfg_done)
		// Every table entry reaches the local output with the register bypassed
		for (int v = 0; v < 16; v++) begin
			@(posedge clk);
			cell_data[3:0] <= v[3:0];
			wait_cyc(2);
			`CHK("local_out0", cfg_mask[v], local_out[0])
		end
		// Cell 1 disabled, cell 7 table gives 0 and breaks the AND cascade
		@(posedge clk);
		cell_data <= 32'h31111121;
		wait_cyc(2);
		`CHK("cascade_out", 1'b0, cascade_out)
		`CHK("carry_out", 1'b0, carry_out)
		@(posedge clk);
		internal_ctl <= 4'hD;
		wait_cyc(4);
		`CHK("route_out", 8'h7D, route_out)
		`CHK("local_out", 8'h7F, local_out)
		// Clear and preset lines low together hit their own cells only
		@(posedge clk);
		internal_ctl <= 4'h1;
		wait_cyc(3);
		`CHK("route_out", 8'h7E, route_out)
		// Second reset, mid-row cluster: both chains pass the neighbour values on
		@(posedge clk);
		rst_n <= 1'b0;
		cluster_idx <= 6'h04;
		cell_data <= 32'h11111111;
		internal_ctl <= 4'hC;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		wait_cyc(2);
		`CHK("carry_out", ~carry_in, carry_out)
		`CHK("cascade_out", ~cascade_in, cascade_out)
		end_sim();
	end
endmodule
